// *** rtl/usart_cfg_pkg.sv ***
/*
 * Package for the serial transceiver command and line configuration block:
 * register offsets, field positions, mode codes and the carried struct.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses below 0x100.
 */
package usart_cfg_pkg;
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_LINE = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_WPROT = 8'he4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Command register bit positions.
	localparam int CMD_RX_RESET = 2;
	localparam int CMD_TX_RESET = 3;
	localparam int CMD_RX_EN = 4;
	localparam int CMD_RX_DIS = 5;
	localparam int CMD_TX_EN = 6;
	localparam int CMD_TX_DIS = 7;
	localparam int CMD_STATUS_CLR = 8;
	localparam int CMD_FORCE_SEL = 18;
	localparam int CMD_RELEASE_SEL = 19;
	// Line configuration field positions; the SPI view reuses some bits.
	localparam int LC_MODE = 0;
	localparam int LC_CLKSRC = 4;
	localparam int LC_CHAR_LENGTH_FIELD = 6;
	localparam int LC_SYNC_CPHA = 8;
	localparam int LC_PARITY = 9;
	localparam int LC_STOP = 12;
	localparam int LC_PATH = 14;
	localparam int LC_CPOL = 16;
	localparam int LC_NINE = 17;
	localparam int LC_CLOCK_OUTPUT_DRIVE = 18;
	localparam int LC_OVER = 19;
	localparam int LC_WAIT_FOR_READ_BEFORE_TX = 20;
	localparam int LC_FILTER = 28;
	localparam logic [31:0] LINE_WMASK = 32'h101f_ffff;
	localparam logic [31:0] LINE_RESET = 32'h0000_0000;
	// Status register bit positions.
	localparam int ST_OVERRUN = 5;
	localparam int ST_UNDERRUN = 10;
	localparam int ST_RX_ON = 16;
	localparam int ST_TX_ON = 17;
	localparam int WP_ENABLE = 0;
	localparam logic [3:0] MODE_SPI_MASTER = 4'he;
	localparam logic [3:0] MODE_SPI_SLAVE = 4'hf;
	localparam logic [1:0] SRC_PCLK = 2'h0;
	localparam logic [1:0] SRC_PCLK_DIV = 2'h1;
	localparam logic [1:0] SRC_EXT_SCK = 2'h3;
	localparam logic [2:0] DIV_LAST = 3'h7;
	localparam logic [1:0] CHAR_LENGTH_FIELD_8BIT = 2'h3;
	localparam logic [3:0] CHAR_MIN = 4'h5;
	localparam logic [3:0] CHAR_NINE = 4'h9;
	localparam logic [1:0] STOP_ONE_HALF = 2'h1;
	localparam logic [1:0] STOP_TWO = 2'h2;
	localparam logic [2:0] HALVES_1 = 3'h2;
	localparam logic [2:0] HALVES_15 = 3'h3;
	localparam logic [2:0] HALVES_2 = 3'h4;
	typedef enum logic [1:0] {PATH_NORMAL, PATH_ECHO, PATH_LOCAL, PATH_REMOTE} path_e;
	typedef struct packed {
		logic [3:0] mode;
		logic spi_master;
		logic spi_slave;
		logic [1:0] clk_src;
		logic [3:0] char_bits;
		logic sync;
		logic [2:0] parity;
		logic [2:0] stop_halves;
		path_e path;
		logic oversample8;
		logic filter_on;
		logic cpha;
		logic cpol;
		logic wait_rd;
	} line_cfg_s;
endpackage : usart_cfg_pkg

// *** rtl/usart_ctrl.sv ***
/*
 * Command strobes, line configuration and SPI select control of a serial
 * transceiver, behind an AXI4-Lite slave. Assumes the shifters, baud
 * generator and receiver sit outside and use the controls driven here;
 * all inputs except the asynchronous reset ARST_N are synchronous to CLK.
 */
`timescale 1ns/1ps
`default_nettype none
module usart_ctrl (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic RXD,
	input wire logic TX_OUT,
	input wire logic XFER_ACTIVE,
	input wire logic TX_CHAR_WRITTEN,
	input wire logic RX_READY,
	input wire logic SAMPLE_TICK,
	input wire logic SCK_IN,
	input wire logic OVERRUN_EVENT,
	input wire logic UNDERRUN_EVENT,
	output logic TXD,
	output logic RX_IN,
	output logic RX_ENABLED,
	output logic TX_ENABLED,
	output logic RX_RESET,
	output logic TX_RESET,
	output logic TX_START,
	output logic BIT_TICK,
	output logic SCK_OUT,
	output logic SCK_OE,
	output logic SLAVE_SELECT_N,
	output logic OVERRUN_FLAG,
	output logic UNDERRUN_FLAG,
	output usart_cfg_pkg::line_cfg_s LINE_CFG
);
	typedef struct packed {
		logic awready;
		logic aw_got;
		logic [7:0] aw_addr;
		logic wready;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [31:0] line;
		logic wprot;
		logic rx_en;
		logic tx_en;
		logic rx_rst;
		logic tx_rst;
		logic ovr;
		logic unr;
		logic forced;
		usart_cfg_pkg::line_cfg_s cfg;
		logic [2:0] div_cnt;
		logic bit_tick;
		logic sck_prev;
		logic sck_out;
		logic sck_oe;
		logic nss_n;
		logic txd;
		logic rx_in;
		logic [2:0] filt;
		logic tx_pending;
		logic tx_start;
	} st_s;

	st_s st_q;
	st_s st_d;
	logic fire;
	logic [31:0] cmd;
	logic [31:0] bytemask;
	logic line_we;
	logic [7:0] rd_addr;
	logic [7:0] wr_addr;
	logic spi_mode;
	logic rx_major;
	assign wr_addr = {st_q.aw_addr[7:2], 2'h0};
	assign rd_addr = {S_AXI_ARADDR[7:2], 2'h0};
	assign fire = st_q.aw_got && st_q.w_got && !st_q.bvalid;
	assign bytemask = {{8{st_q.w_strb[3]}}, {8{st_q.w_strb[2]}},
		{8{st_q.w_strb[1]}}, {8{st_q.w_strb[0]}}};
	assign cmd = (fire && wr_addr == usart_cfg_pkg::ADDR_CMD) ? (st_q.w_data & bytemask) : '0;
	assign line_we = fire && wr_addr == usart_cfg_pkg::ADDR_LINE && !st_q.wprot;
	assign spi_mode = st_q.cfg.spi_master || st_q.cfg.spi_slave;
	assign rx_major = (st_q.filt[0] & st_q.filt[1]) | (st_q.filt[1] & st_q.filt[2])
		| (st_q.filt[0] & st_q.filt[2]);
	always_comb begin
		logic [31:0] ln;
		logic rx_src;
		logic spi_d;
		ln = '0;
		rx_src = 1'b0;
		spi_d = 1'b0;
		st_d = st_q;
		st_d.tx_rst = 1'b0;
		st_d.tx_start = 1'b0;
		// Write channel: address and data are taken in either order.
		if (S_AXI_AWVALID && st_q.awready) begin
			st_d.aw_got = 1'b1;
			st_d.aw_addr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && st_q.wready) begin
			st_d.w_got = 1'b1;
			st_d.w_data = S_AXI_WDATA;
			st_d.w_strb = S_AXI_WSTRB;
		end
		if (fire) begin
			st_d.aw_got = 1'b0;
			st_d.w_got = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = usart_cfg_pkg::RESP_OKAY;
			if (wr_addr != usart_cfg_pkg::ADDR_CMD && wr_addr != usart_cfg_pkg::ADDR_LINE
				&& wr_addr != usart_cfg_pkg::ADDR_STATUS
				&& wr_addr != usart_cfg_pkg::ADDR_WPROT) begin
				st_d.bresp = usart_cfg_pkg::RESP_SLVERR;
			end
			if (wr_addr == usart_cfg_pkg::ADDR_WPROT && st_q.w_strb[0]) begin
				st_d.wprot = st_q.w_data[usart_cfg_pkg::WP_ENABLE];
			end
		end else if (st_q.bvalid && S_AXI_BREADY) begin
			st_d.bvalid = 1'b0;
		end
		st_d.awready = !st_d.aw_got && !st_d.bvalid;
		st_d.wready = !st_d.w_got && !st_d.bvalid;
		// Read channel: one cycle from address to data.
		if (S_AXI_ARVALID && st_q.arready) begin
			st_d.rvalid = 1'b1;
			st_d.rresp = usart_cfg_pkg::RESP_OKAY;
			st_d.rdata = '0;
			case (rd_addr)
				usart_cfg_pkg::ADDR_CMD: st_d.rdata = '0;
				usart_cfg_pkg::ADDR_LINE: st_d.rdata = st_q.line;
				usart_cfg_pkg::ADDR_STATUS: begin
					st_d.rdata[usart_cfg_pkg::ST_OVERRUN] = st_q.ovr;
					st_d.rdata[usart_cfg_pkg::ST_UNDERRUN] = st_q.unr;
					st_d.rdata[usart_cfg_pkg::ST_RX_ON] = st_q.rx_en;
					st_d.rdata[usart_cfg_pkg::ST_TX_ON] = st_q.tx_en;
				end
				usart_cfg_pkg::ADDR_WPROT: st_d.rdata[usart_cfg_pkg::WP_ENABLE] = st_q.wprot;
				default: st_d.rresp = usart_cfg_pkg::RESP_SLVERR;
			endcase
		end else if (st_q.rvalid && S_AXI_RREADY) begin
			st_d.rvalid = 1'b0;
		end
		st_d.arready = !st_d.rvalid;
		// Command strobes; a zero bit leaves state alone.
		st_d.rx_rst = cmd[usart_cfg_pkg::CMD_RX_RESET];
		if (cmd[usart_cfg_pkg::CMD_TX_RESET]) begin
			st_d.tx_rst = 1'b1;
			st_d.tx_pending = 1'b0;
		end
		if (cmd[usart_cfg_pkg::CMD_RX_DIS]) begin
			st_d.rx_en = 1'b0;
		end else if (cmd[usart_cfg_pkg::CMD_RX_EN]) begin
			st_d.rx_en = 1'b1;
		end
		if (cmd[usart_cfg_pkg::CMD_TX_DIS]) begin
			st_d.tx_en = 1'b0;
		end else if (cmd[usart_cfg_pkg::CMD_TX_EN]) begin
			st_d.tx_en = 1'b1;
		end
		// Error flags: a new event wins over a clear in the same cycle.
		if (cmd[usart_cfg_pkg::CMD_STATUS_CLR]) begin
			st_d.ovr = 1'b0;
			if (spi_mode) begin
				st_d.unr = 1'b0;
			end
		end
		st_d.ovr = st_d.ovr || OVERRUN_EVENT;
		st_d.unr = st_d.unr || (UNDERRUN_EVENT && spi_mode);
		if (st_q.cfg.spi_master) begin
			if (cmd[usart_cfg_pkg::CMD_RELEASE_SEL]) begin
				st_d.forced = 1'b0;
			end else if (cmd[usart_cfg_pkg::CMD_FORCE_SEL]) begin
				st_d.forced = 1'b1;
			end
		end
		// Line configuration and its decoded view.
		if (line_we) begin
			st_d.line = (st_q.line & ~(bytemask & usart_cfg_pkg::LINE_WMASK))
				| (st_q.w_data & bytemask & usart_cfg_pkg::LINE_WMASK);
		end
		ln = st_d.line;
		st_d.cfg.mode = ln[usart_cfg_pkg::LC_MODE +: 4];
		st_d.cfg.spi_master = ln[usart_cfg_pkg::LC_MODE +: 4] == usart_cfg_pkg::MODE_SPI_MASTER;
		st_d.cfg.spi_slave = ln[usart_cfg_pkg::LC_MODE +: 4] == usart_cfg_pkg::MODE_SPI_SLAVE;
		spi_d = st_d.cfg.spi_master || st_d.cfg.spi_slave;
		st_d.cfg.clk_src = ln[usart_cfg_pkg::LC_CLKSRC +: 2];
		st_d.cfg.char_bits = usart_cfg_pkg::CHAR_MIN + {2'h0, ln[usart_cfg_pkg::LC_CHAR_LENGTH_FIELD +: 2]};
		if (spi_d) begin
			st_d.cfg.char_bits = usart_cfg_pkg::CHAR_MIN + {2'h0, usart_cfg_pkg::CHAR_LENGTH_FIELD_8BIT};
		end else if (ln[usart_cfg_pkg::LC_NINE]) begin
			st_d.cfg.char_bits = usart_cfg_pkg::CHAR_NINE;
		end
		st_d.cfg.sync = !spi_d && ln[usart_cfg_pkg::LC_SYNC_CPHA];
		st_d.cfg.cpha = spi_d && ln[usart_cfg_pkg::LC_SYNC_CPHA];
		st_d.cfg.cpol = spi_d && ln[usart_cfg_pkg::LC_CPOL];
		st_d.cfg.parity = spi_d ? 3'h0 : ln[usart_cfg_pkg::LC_PARITY +: 3];
		st_d.cfg.stop_halves = usart_cfg_pkg::HALVES_1;
		if (ln[usart_cfg_pkg::LC_STOP +: 2] == usart_cfg_pkg::STOP_TWO) begin
			st_d.cfg.stop_halves = usart_cfg_pkg::HALVES_2;
		end else if (ln[usart_cfg_pkg::LC_STOP +: 2] == usart_cfg_pkg::STOP_ONE_HALF
			&& !st_d.cfg.sync) begin
			st_d.cfg.stop_halves = usart_cfg_pkg::HALVES_15;
		end
		st_d.cfg.path = spi_d ? usart_cfg_pkg::PATH_NORMAL
			: usart_cfg_pkg::path_e'(ln[usart_cfg_pkg::LC_PATH +: 2]);
		st_d.cfg.oversample8 = ln[usart_cfg_pkg::LC_OVER];
		st_d.cfg.filter_on = ln[usart_cfg_pkg::LC_FILTER];
		st_d.cfg.wait_rd = spi_d && ln[usart_cfg_pkg::LC_WAIT_FOR_READ_BEFORE_TX];
		// Bit clock source selection.
		st_d.sck_prev = SCK_IN;
		st_d.bit_tick = 1'b0;
		case (st_q.cfg.clk_src)
			usart_cfg_pkg::SRC_PCLK: st_d.bit_tick = 1'b1;
			usart_cfg_pkg::SRC_PCLK_DIV: begin
				st_d.div_cnt = st_q.div_cnt + 3'h1;
				st_d.bit_tick = st_q.div_cnt == usart_cfg_pkg::DIV_LAST;
			end
			usart_cfg_pkg::SRC_EXT_SCK: st_d.bit_tick = SCK_IN && !st_q.sck_prev;
			default: st_d.bit_tick = 1'b0;
		endcase
		st_d.sck_oe = ln[usart_cfg_pkg::LC_CLOCK_OUTPUT_DRIVE]
			&& st_d.cfg.clk_src != usart_cfg_pkg::SRC_EXT_SCK;
		// In SPI master mode the clock rests at its polarity level outside transfers.
		if (st_q.cfg.spi_master && !XFER_ACTIVE) begin
			st_d.sck_out = st_q.cfg.cpol;
		end else if (st_q.bit_tick) begin
			st_d.sck_out = !st_q.sck_out;
		end
		st_d.nss_n = !(st_d.cfg.spi_master && (st_d.forced || XFER_ACTIVE));
		// Receive line filter and channel path.
		st_d.filt = SAMPLE_TICK ? {st_q.filt[1:0], RXD} : st_q.filt;
		rx_src = st_q.cfg.filter_on ? rx_major : RXD;
		case (st_q.cfg.path)
			usart_cfg_pkg::PATH_NORMAL: begin
				st_d.txd = TX_OUT;
				st_d.rx_in = rx_src;
			end
			usart_cfg_pkg::PATH_ECHO: begin
				st_d.txd = RXD;
				st_d.rx_in = rx_src;
			end
			usart_cfg_pkg::PATH_LOCAL: begin
				st_d.txd = 1'b1;
				st_d.rx_in = TX_OUT;
			end
			usart_cfg_pkg::PATH_REMOTE: begin
				st_d.txd = RXD;
				st_d.rx_in = 1'b1;
			end
			default: begin
				st_d.txd = 1'b1;
				st_d.rx_in = 1'b1;
			end
		endcase
		// Transmit start waits for the receive holding data to be read when wait_rd is set (SPI mode only).
		st_d.tx_pending = st_d.tx_pending || (TX_CHAR_WRITTEN && st_q.tx_en);
		if (st_q.tx_pending && st_q.tx_en && !st_q.tx_rst
			&& !(st_q.cfg.wait_rd && RX_READY)) begin
			st_d.tx_start = 1'b1;
			st_d.tx_pending = 1'b0;
		end
	end
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			st_q <= '0;
			st_q.awready <= 1'b1;
			st_q.wready <= 1'b1;
			st_q.arready <= 1'b1;
			st_q.line <= usart_cfg_pkg::LINE_RESET;
			st_q.cfg.char_bits <= usart_cfg_pkg::CHAR_MIN;
			st_q.cfg.stop_halves <= usart_cfg_pkg::HALVES_1;
			st_q.nss_n <= 1'b1;
			st_q.txd <= 1'b1;
			st_q.rx_in <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end
	assign S_AXI_AWREADY = st_q.awready;
	assign S_AXI_WREADY = st_q.wready;
	assign S_AXI_BVALID = st_q.bvalid;
	assign S_AXI_BRESP = st_q.bresp;
	assign S_AXI_ARREADY = st_q.arready;
	assign S_AXI_RVALID = st_q.rvalid;
	assign S_AXI_RDATA = st_q.rdata;
	assign S_AXI_RRESP = st_q.rresp;
	assign TXD = st_q.txd;
	assign RX_IN = st_q.rx_in;
	assign RX_ENABLED = st_q.rx_en;
	assign TX_ENABLED = st_q.tx_en;
	assign RX_RESET = st_q.rx_rst;
	assign TX_RESET = st_q.tx_rst;
	assign TX_START = st_q.tx_start;
	assign BIT_TICK = st_q.bit_tick;
	assign SCK_OUT = st_q.sck_out;
	assign SCK_OE = st_q.sck_oe;
	assign SLAVE_SELECT_N = st_q.nss_n;
	assign OVERRUN_FLAG = st_q.ovr;
	assign UNDERRUN_FLAG = st_q.unr;
	assign LINE_CFG = st_q.cfg;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);

	a_rx_reset_pulse: assert property (cmd[usart_cfg_pkg::CMD_RX_RESET] |=> RX_RESET ##1 !RX_RESET)
		else $error("Receiver reset pulse missing.");
	a_tx_reset_pulse: assert property (TX_RESET |-> $past(cmd[usart_cfg_pkg::CMD_TX_RESET]))
		else $error("Transmitter reset without command.");
	a_rx_enable_cmd: assert property ((cmd[usart_cfg_pkg::CMD_RX_EN]
		&& !cmd[usart_cfg_pkg::CMD_RX_DIS]) |=> RX_ENABLED)
		else $error("Receiver not enabled.");
	a_rx_disable_cmd: assert property (cmd[usart_cfg_pkg::CMD_RX_DIS] |=> !RX_ENABLED)
		else $error("Receiver not disabled.");
	a_tx_enable_cmd: assert property ((cmd[usart_cfg_pkg::CMD_TX_EN]
		&& !cmd[usart_cfg_pkg::CMD_TX_DIS]) |=> TX_ENABLED)
		else $error("Transmitter not enabled.");
	a_tx_disable_cmd: assert property (cmd[usart_cfg_pkg::CMD_TX_DIS] |=> !TX_ENABLED)
		else $error("Transmitter not disabled.");
	a_status_clear_flags: assert property ((cmd[usart_cfg_pkg::CMD_STATUS_CLR] && spi_mode
		&& !OVERRUN_EVENT && !UNDERRUN_EVENT) |=> !OVERRUN_FLAG && !UNDERRUN_FLAG)
		else $error("Error flags not cleared.");
	a_force_select_low: assert property ((cmd[usart_cfg_pkg::CMD_FORCE_SEL]
		&& !cmd[usart_cfg_pkg::CMD_RELEASE_SEL] && LINE_CFG.spi_master && !line_we)
		|=> !SLAVE_SELECT_N)
		else $error("Select not forced low.");
	a_release_select: assert property ((cmd[usart_cfg_pkg::CMD_RELEASE_SEL] && !XFER_ACTIVE)
		|=> SLAVE_SELECT_N)
		else $error("Select not released.");
	a_protect_blocks: assert property ((fire && wr_addr == usart_cfg_pkg::ADDR_LINE
		&& st_q.wprot) |=> $stable(st_q.line))
		else $error("Protected write changed line config.");
	a_spi_char_eight: assert property ((LINE_CFG.spi_master || LINE_CFG.spi_slave)
		|-> LINE_CFG.char_bits == usart_cfg_pkg::CHAR_MIN + {2'h0, usart_cfg_pkg::CHAR_LENGTH_FIELD_8BIT})
		else $error("SPI character not eight bits.");
	a_clk_out_drive: assert property (SCK_OE |-> LINE_CFG.clk_src
		!= usart_cfg_pkg::SRC_EXT_SCK)
		else $error("Clock pin driven with external source.");
	a_tx_wait_read: assert property (TX_START |-> !($past(LINE_CFG.wait_rd)
		&& $past(RX_READY)))
		else $error("Transmit started while receive ready.");
	a_write_resp_time: assert property ((S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
		&& S_AXI_WREADY) |=> ##1 S_AXI_BVALID)
		else $error("Write response late.");

	c_force_select: cover property (cmd[usart_cfg_pkg::CMD_FORCE_SEL] && LINE_CFG.spi_master);
	c_protected_write: cover property (fire && wr_addr == usart_cfg_pkg::ADDR_LINE && st_q.wprot);
	c_tx_start: cover property (TX_START && LINE_CFG.wait_rd);
	c_flag_set_clear: cover property (cmd[usart_cfg_pkg::CMD_STATUS_CLR] && OVERRUN_EVENT);
endmodule : usart_ctrl
`default_nettype wire

// *** tb/usart_peer_model.sv ***
/*
 * Far-side model: serial peer, shifter and receive-holding signals seen by
 * the control block. Assumes the bench asks for each event on REQ.
 */
`timescale 1ns/1ps
`default_nettype none
module usart_peer_model (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic CPOL,
	input wire logic [5:0] REQ,
	output logic RXD,
	output logic TX_OUT,
	output logic XFER_ACTIVE,
	output logic TX_CHAR_WRITTEN,
	output logic RX_READY,
	output logic SAMPLE_TICK,
	output logic SCK_IN,
	output logic OVERRUN_EVENT,
	output logic UNDERRUN_EVENT
);
	logic [1:0] cnt_q;
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			cnt_q <= 2'h0;
			{RXD, XFER_ACTIVE, TX_CHAR_WRITTEN, RX_READY, OVERRUN_EVENT, UNDERRUN_EVENT} <= 6'h20;
			{SAMPLE_TICK, SCK_IN, TX_OUT} <= 3'h0;
		end else begin
			cnt_q <= cnt_q + 2'h1;
			{RXD, XFER_ACTIVE, TX_CHAR_WRITTEN, RX_READY, OVERRUN_EVENT, UNDERRUN_EVENT} <= REQ;
			SAMPLE_TICK <= (cnt_q == 2'h3);
			// The clock rests at its idle level outside transfers.
			SCK_IN <= REQ[4] ? ~SCK_IN : CPOL;
			TX_OUT <= ~TX_OUT;
		end
	end
endmodule : usart_peer_model
`default_nettype wire

// *** tb/tb_top.sv ***
/*
 * Self-checking bench for the command and line configuration block.
 * Assumes the far side is the peer model and the bus is AXI4-Lite.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic CLK = 1'b0;
	logic ARST_N = 1'b0;
	logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
	logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
	logic [3:0] S_AXI_WSTRB = 4'hf;
	logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
	logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rpulse;
	logic RXD, TX_OUT, XFER_ACTIVE, TX_CHAR_WRITTEN, RX_READY, SAMPLE_TICK, SCK_IN;
	logic OVERRUN_EVENT, UNDERRUN_EVENT, TXD, RX_IN, RX_ENABLED, TX_ENABLED, RX_RESET;
	logic TX_RESET, TX_START, BIT_TICK, SCK_OUT, SCK_OE, SLAVE_SELECT_N;
	logic OVERRUN_FLAG, UNDERRUN_FLAG;
	usart_cfg_pkg::line_cfg_s LINE_CFG, e;
	logic [5:0] req = 6'h20;
	logic [31:0] seed = 32'h43ee0b60, v;
	int n_errors = 0, checked = 0, n_tick = 0;
	logic [31:0] cmd [9] = '{32'h50, 32'h0, 32'h30, 32'h10, 32'hc0, 32'h40, 32'ha0, 32'h4, 32'h8};
	logic [3:0] exp4 [9] = '{4'hc, 4'hc, 4'h4, 4'hc, 4'h8, 4'hc, 4'h0, 4'h2, 4'h1};

	usart_ctrl u_dut (.*);
	usart_peer_model u_peer (.CPOL(LINE_CFG.cpol), .REQ(req), .*);

	always #2.5 CLK = ~CLK;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		@(posedge CLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
		do begin
			@(posedge CLK);
			if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
			if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
		end while (!S_AXI_BVALID);
		r = S_AXI_BRESP;
		rpulse = {RX_RESET, TX_RESET};
		S_AXI_BREADY <= 1'b0;
		@(negedge CLK);
		chk(32'(r), 32'(er));
	endtask : wr

	task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		@(posedge CLK);
		S_AXI_ARADDR <= a;
		{S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
		do begin
			@(posedge CLK);
			if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
		end while (!S_AXI_RVALID);
		chk(S_AXI_RDATA, exp);
		chk(32'(S_AXI_RRESP), 32'(er));
		S_AXI_RREADY <= 1'b0;
		@(negedge CLK);
	endtask : rc

	// Offers one character with the receive-holding level given, counts starts.
	task automatic txs(input logic rdy, input int exp);
		int c = 0;
		@(posedge CLK);
		req[3:2] <= {1'b1, rdy};
		@(posedge CLK);
		req[3] <= 1'b0;
		repeat (10) begin
			@(posedge CLK);
			c += int'(TX_START);
		end
		chk(32'(c), 32'(exp));
	endtask : txs

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs

	function automatic usart_cfg_pkg::line_cfg_s dec(input logic [31:0] x);
		usart_cfg_pkg::line_cfg_s d;
		d = '0;
		d.mode = x[3:0];
		d.clk_src = x[5:4];
		d.char_bits = x[17] ? 4'h9 : 4'h5 + 4'(x[7:6]);
		d.sync = x[8];
		d.parity = x[11:9];
		d.stop_halves = x[13] ? 3'h4 : (x[12] && !x[8]) ? 3'h3 : 3'h2;
		d.path = usart_cfg_pkg::path_e'(x[15:14]);
		d.oversample8 = x[19];
		d.filter_on = x[28];
		return d;
	endfunction : dec

	task automatic summarize();
		if (n_errors == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : summarize

	initial begin
		#50000;
		n_errors++;
		summarize();
	end

	initial begin
		repeat (6) @(posedge CLK);
		ARST_N <= 1'b1;
		@(negedge CLK);
		chk(32'({TXD, RX_IN, SLAVE_SELECT_N, RX_ENABLED, TX_ENABLED}), 32'h1c);
		rc(usart_cfg_pkg::ADDR_LINE, 32'h0, usart_cfg_pkg::RESP_OKAY);
		for (int i = 0; i < 9; i++) begin
			wr(usart_cfg_pkg::ADDR_CMD, cmd[i], usart_cfg_pkg::RESP_OKAY);
			chk(32'({RX_ENABLED, TX_ENABLED, rpulse}), 32'(exp4[i]));
		end
		rc(usart_cfg_pkg::ADDR_CMD, 32'h0, usart_cfg_pkg::RESP_OKAY);
		wr(8'h08, 32'h0, usart_cfg_pkg::RESP_SLVERR);
		rc(8'h08, 32'h0, usart_cfg_pkg::RESP_SLVERR);
		for (int i = 0; i < 20; i++) begin
			seed = xs(seed);
			@(posedge CLK);
			req[5:4] <= seed[31:30];
			v = seed & usart_cfg_pkg::LINE_WMASK;
			v[3] = 1'b0;
			if (v[13:12] == 2'h3) v[12] = 1'b0;
			wr(usart_cfg_pkg::ADDR_LINE, v, usart_cfg_pkg::RESP_OKAY);
			rc(usart_cfg_pkg::ADDR_LINE, v, usart_cfg_pkg::RESP_OKAY);
			e = dec(v);
			chk(32'(LINE_CFG), 32'(e));
			chk(32'(SCK_OE), 32'(v[18] && v[5:4] != 2'h3));
			n_tick = 0;
			repeat (16) begin
				@(posedge CLK);
				n_tick += int'(BIT_TICK);
			end
			chk(32'(n_tick), (v[5:4] == 2'h0) ? 32'h10 : (v[5:4] == 2'h1) ? 32'h2
				: (v[5:4] == 2'h3 && seed[30]) ? 32'h8 : 32'h0);
			@(negedge CLK);
			chk(32'(TXD), 32'(v[15:14] == 2'h2 ? 1'b1 : v[14] ? RXD : !TX_OUT));
			chk(32'(RX_IN), 32'(v[15:14] == 2'h3 ? 1'b1 : v[15] ? !TX_OUT : RXD));
		end
		@(posedge CLK);
		req[4] <= 1'b0;
		wr(usart_cfg_pkg::ADDR_WPROT, 32'h1, usart_cfg_pkg::RESP_OKAY);
		wr(usart_cfg_pkg::ADDR_LINE, ~v & 32'h0000_ffff, usart_cfg_pkg::RESP_OKAY);
		rc(usart_cfg_pkg::ADDR_LINE, v, usart_cfg_pkg::RESP_OKAY);
		wr(usart_cfg_pkg::ADDR_WPROT, 32'h0, usart_cfg_pkg::RESP_OKAY);
		wr(usart_cfg_pkg::ADDR_LINE, 32'h0000_000f, usart_cfg_pkg::RESP_OKAY);
		chk(32'({LINE_CFG.spi_master, LINE_CFG.spi_slave}), 32'h1);
		wr(usart_cfg_pkg::ADDR_LINE, 32'h0001_010e, usart_cfg_pkg::RESP_OKAY);
		chk(32'({LINE_CFG.spi_master, LINE_CFG.spi_slave}), 32'h2);
		chk(32'({LINE_CFG.cpha, LINE_CFG.cpol, LINE_CFG.sync}), 32'h6);
		chk(32'(LINE_CFG.char_bits), 32'h8);
		chk(32'(SCK_OUT), 32'h1);
		wr(usart_cfg_pkg::ADDR_CMD, 32'h0004_0000, usart_cfg_pkg::RESP_OKAY);
		chk(32'(SLAVE_SELECT_N), 32'h0);
		wr(usart_cfg_pkg::ADDR_CMD, 32'h0008_0000, usart_cfg_pkg::RESP_OKAY);
		chk(32'(SLAVE_SELECT_N), 32'h1);
		@(posedge CLK);
		req[1:0] <= 2'h3;
		@(posedge CLK);
		req[1:0] <= 2'h0;
		repeat (3) @(posedge CLK);
		rc(usart_cfg_pkg::ADDR_STATUS, 32'h0000_0420, usart_cfg_pkg::RESP_OKAY);
		wr(usart_cfg_pkg::ADDR_CMD, 32'h0000_0100, usart_cfg_pkg::RESP_OKAY);
		chk(32'({OVERRUN_FLAG, UNDERRUN_FLAG}), 32'h0);
		rc(usart_cfg_pkg::ADDR_STATUS, 32'h0, usart_cfg_pkg::RESP_OKAY);
		wr(usart_cfg_pkg::ADDR_CMD, 32'h0000_0040, usart_cfg_pkg::RESP_OKAY);
		wr(usart_cfg_pkg::ADDR_LINE, 32'h0011_000e, usart_cfg_pkg::RESP_OKAY);
		txs(1'b1, 0);
		txs(1'b0, 1);
		wr(usart_cfg_pkg::ADDR_LINE, 32'h0001_000e, usart_cfg_pkg::RESP_OKAY);
		txs(1'b1, 1);
		summarize();
	end
endmodule : tb_top
`default_nettype wire
